// >>> hdl/nem_defines.svh
// constants for the nibble, extend, multiply and negate datapath slice
// assumes the core decoder presents one decoded instruction per request
//
// Operation
// RULE_01: nibble move copies one four-bit field
// RULE_02: software pairs nibble move with accumulator low byte
// RULE_03: nibble move keeps other half, no flags
// RULE_04: extend move replicates immediate bit seven upward
// RULE_05: extend move into pointer writes low 24
// RULE_06: extend move flags use full 32 bits
// RULE_07: software keeps extend immediate within signed byte
// RULE_08: extend move sign is msb, zero exact
// RULE_09: wide signed multiply gives 48-bit triple result
// RULE_10: unsigned multiply treats operands unsigned, writes dest
// RULE_11: byte multiply takes 8-bit, gives 16-bit
// RULE_12: byte multiply pointer low 8, upper zero
// RULE_13: software restricts word multiply destination registers
// RULE_14: word multiply into word regs fills pairs
// RULE_15: word multiply pointer dest low 24, src 16
// RULE_16: long multiply to first pair, low 32
// RULE_17: software avoids pointer source and dest byte
// RULE_18: negate replaces dest with zero minus dest
// RULE_19: negate overflow only for most negative value
// RULE_20: negate carry set on zero result
// RULE_21: negate, invert: sign msb, zero exact
// RULE_22: word negate, invert pointer upper eight zero
// RULE_23: idle instruction only advances program counter
// RULE_24: invert complements every destination bit
// RULE_25: both multiplies leave flags unchanged
`ifndef NEM_DEFINES_SVH
`define NEM_DEFINES_SVH
`define NEM_REG_AW 4
`define NEM_OFF_CTRL 4'h0
`define NEM_OFF_STAT 4'h4
`define NEM_CTRL_EN_BIT 0
`define NEM_CTRL_RST 32'h0000_0001
`define NEM_STAT_CNT_LSB 0
`define NEM_STAT_FLG_LSB 16
`define NEM_NEG_MIN_B 8'h80
`define NEM_NEG_MIN_W 16'h8000
`define NEM_PC_STEP 4'h1
`endif

// >>> hdl/nem_pkg.sv
// types shared by the datapath slice and its bench
// assumes the decoder fills a request struct each accepted cycle
package nem_pkg;
  typedef enum logic [2:0] {
    OP_NIBBLE = 3'h0, OP_EXTMOV = 3'h1, OP_SIGNED_WIDE_MULTIPLY = 3'h2, OP_UNSIGNED_MULTIPLY = 3'h3,
    OP_NEG = 3'h4, OP_IDLE = 3'h5, OP_NOT = 3'h6
  } nem_op_type;
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2
  } nem_size_type;
  typedef enum logic [1:0] {
    DIR_HH = 2'h0, DIR_HL = 2'h1, DIR_LH = 2'h2, DIR_LL = 2'h3
  } nem_dir_type;
  // where the result is to be written
  typedef enum logic [2:0] {
    TG_NONE = 3'h0, TG_DEST = 3'h1, TG_FIRST_PAIR = 3'h2,
    TG_SECOND_PAIR = 3'h3, TG_TRIPLE = 3'h4
  } nem_target_type;
  // how many result bits are meaningful
  typedef enum logic [2:0] {
    WW_BYTE = 3'h0, WW_WORD = 3'h1, WW_LONG = 3'h2,
    WW_ADDR24 = 3'h3, WW_WIDE48 = 3'h4
  } nem_width_type;
  typedef struct packed {
    nem_op_type op;
    nem_size_type size;
    nem_dir_type dir;
    logic src_is_addr;
    logic dst_is_addr;
    logic dst_word_one;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] pair;
  } nem_req_type;
  typedef struct packed {
    logic s;
    logic z;
    logic o;
    logic c;
  } nem_flags_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01, ST_DONE = 2'b10
  } nem_state_type;
endpackage : nem_pkg

// >>> hdl/nem_alu.sv
// execution slice: nibble move, extend move, multiplies, negate, idle, invert
// assumes decoded operands arrive with the request and that the core
// writes the result back to the target named in the answer
//
// The address map and strobed register access were decided locally.
`include "nem_defines.svh"
module nem_alu #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // decoded request
  input wire logic i_req_valid,
  input wire nem_pkg::nem_req_type i_req,
  // result
  output logic o_done,
  output logic o_refused,
  output nem_pkg::nem_target_type o_target,
  output nem_pkg::nem_width_type o_width,
  output logic [47:0] o_result,
  output nem_pkg::nem_flags_type o_flag_we,
  output nem_pkg::nem_flags_type o_flags,
  output logic [3:0] o_pc_inc,
  // register port
  input wire logic [`NEM_REG_AW-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata
);

  // the counter field is 16 bits wide in the status word
  if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
    $error("nem_alu: CNT_W must be 1 to 16");
  end

  // request fields
  wire nem_pkg::nem_op_type op = i_req.op;
  wire nem_pkg::nem_size_type sz = i_req.size;
  wire nem_pkg::nem_dir_type dir = i_req.dir;
  wire logic [31:0] src = i_req.src;
  wire logic [31:0] dst = i_req.dst;
  wire logic is_byte = (sz == nem_pkg::SZ_BYTE);
  wire logic is_word = (sz == nem_pkg::SZ_WORD);

  // control register: enable gates acceptance of requests
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  nem_pkg::nem_flags_type last_flg_reg;
  nem_pkg::nem_flags_type last_flg_next;
  wire logic enabled = ctrl_reg[`NEM_CTRL_EN_BIT];
  wire logic accept = i_req_valid & enabled;
  wire logic refuse = i_req_valid & ~enabled;

  // nibble move: pick the source half, place it, keep the other half
  wire logic nib_from_high = (dir == nem_pkg::DIR_HH) | (dir == nem_pkg::DIR_HL);
  wire logic nib_to_high = (dir == nem_pkg::DIR_HH) | (dir == nem_pkg::DIR_LH);
  wire logic [3:0] nib_src = nib_from_high ? src[7:4] : src[3:0]; // [RULE_01]
  wire logic [7:0] nib_res = nib_to_high ? {nib_src, dst[3:0]}
                                         : {dst[7:4], nib_src}; // [RULE_01] [RULE_03]

  // extend move: flags on all 32 bits even if a pointer gets only 24
  wire logic [31:0] ext_val = {{24{src[7]}}, src[7:0]}; // [RULE_04]
  wire logic [47:0] ext_res = i_req.dst_is_addr ? {24'h0, ext_val[23:0]}
                                                : {16'h0, ext_val}; // [RULE_05]
  wire logic ext_s = ext_val[31]; // [RULE_06] [RULE_08]
  wire logic ext_z = (ext_val == 32'h0); // [RULE_06] [RULE_08]

  // wide signed multiply: 16-bit source times first pair, 48-bit product
  wire logic signed [47:0] mx_a = $signed({{32{src[15]}}, src[15:0]});
  wire logic signed [47:0] mx_b = $signed({{16{i_req.pair[31]}}, i_req.pair});
  wire logic signed [47:0] mx_p = mx_a * mx_b; // [RULE_09]

  // unsigned multiply operands; pointers contribute only their low bits
  wire logic [31:0] lsrc = i_req.src_is_addr ? {8'h0, src[23:0]} : src; // [RULE_16]
  wire logic [31:0] mu_a = is_byte ? {24'h0, src[7:0]}
                         : is_word ? {16'h0, src[15:0]} : lsrc; // [RULE_12] [RULE_15]
  wire logic [31:0] mu_b = is_byte ? {24'h0, dst[7:0]}
                         : is_word ? {16'h0, dst[15:0]} : dst; // [RULE_12]
  wire logic [63:0] mu_p = {32'h0, mu_a} * {32'h0, mu_b}; // [RULE_10] [RULE_11]
  logic [47:0] mu_res;
  nem_pkg::nem_target_type mu_tg;
  nem_pkg::nem_width_type mu_ww;

  // unsigned multiply write-back by size and destination kind
  always_comb begin
    mu_res = {16'h0, mu_p[31:0]};
    mu_tg = nem_pkg::TG_DEST;
    mu_ww = nem_pkg::WW_LONG;
    if (is_byte) begin
      mu_res = {32'h0, mu_p[15:0]}; // [RULE_11]
      mu_ww = i_req.dst_is_addr ? nem_pkg::WW_ADDR24 : nem_pkg::WW_WORD; // [RULE_12]
    end else if (is_word && i_req.dst_is_addr) begin
      mu_res = {24'h0, mu_p[23:0]}; // [RULE_15]
      mu_ww = nem_pkg::WW_ADDR24;
    end else if (is_word) begin
      mu_tg = i_req.dst_word_one ? nem_pkg::TG_SECOND_PAIR
                                 : nem_pkg::TG_FIRST_PAIR; // [RULE_14]
    end else begin
      mu_tg = nem_pkg::TG_FIRST_PAIR; // [RULE_16]
    end
  end

  // negate and invert at byte or word size
  wire logic [7:0] neg_b = 8'h0 - dst[7:0]; // [RULE_18]
  wire logic [15:0] neg_w = 16'h0 - dst[15:0]; // [RULE_18]
  wire logic [7:0] not_b = ~dst[7:0]; // [RULE_24]
  wire logic [15:0] not_w = ~dst[15:0]; // [RULE_24]
  wire logic is_neg = (op == nem_pkg::OP_NEG);
  wire logic [15:0] un_w = is_neg ? neg_w : not_w;
  wire logic [7:0] un_b = is_neg ? neg_b : not_b;
  wire logic un_s = is_byte ? un_b[7] : un_w[15]; // [RULE_21]
  wire logic un_z = is_byte ? (un_b == 8'h0) : (un_w == 16'h0); // [RULE_21]
  wire logic neg_o = is_byte ? (dst[7:0] == `NEM_NEG_MIN_B)
                             : (dst[15:0] == `NEM_NEG_MIN_W); // [RULE_19]
  // the carry follows a zero result, as the instruction defines it
  wire logic neg_c = un_z; // [RULE_20]
  wire logic un_addr_w = is_word & i_req.dst_is_addr;
  wire logic [47:0] un_res = is_byte ? {40'h0, un_b}
                                     : {32'h0, un_w}; // [RULE_22]

  // operation select
  logic [47:0] res_next;
  nem_pkg::nem_target_type tg_next;
  nem_pkg::nem_width_type ww_next;
  nem_pkg::nem_flags_type we_next;
  nem_pkg::nem_flags_type fl_next;
  logic pc_next;

  always_comb begin
    res_next = 48'h0;
    tg_next = nem_pkg::TG_NONE;
    ww_next = nem_pkg::WW_BYTE;
    we_next = '0;
    fl_next = '0;
    pc_next = 1'b0;
    case (op)
      nem_pkg::OP_NIBBLE: begin
        res_next = {40'h0, nib_res};
        tg_next = nem_pkg::TG_DEST; // [RULE_03] no flag enables
      end
      nem_pkg::OP_EXTMOV: begin
        res_next = ext_res;
        tg_next = nem_pkg::TG_DEST;
        ww_next = i_req.dst_is_addr ? nem_pkg::WW_ADDR24 : nem_pkg::WW_LONG; // [RULE_05]
        we_next.s = 1'b1;
        we_next.z = 1'b1;
        fl_next.s = ext_s; // [RULE_08]
        fl_next.z = ext_z; // [RULE_08]
      end
      nem_pkg::OP_SIGNED_WIDE_MULTIPLY: begin
        res_next = 48'(mx_p);
        tg_next = nem_pkg::TG_TRIPLE; // [RULE_09]
        ww_next = nem_pkg::WW_WIDE48; // [RULE_25] flags untouched
      end
      nem_pkg::OP_UNSIGNED_MULTIPLY: begin
        res_next = mu_res;
        tg_next = mu_tg; // [RULE_10]
        ww_next = mu_ww; // [RULE_25] flags untouched
      end
      nem_pkg::OP_NEG, nem_pkg::OP_NOT: begin
        res_next = un_res;
        tg_next = nem_pkg::TG_DEST;
        ww_next = un_addr_w ? nem_pkg::WW_ADDR24
                : is_byte ? nem_pkg::WW_BYTE : nem_pkg::WW_WORD; // [RULE_22]
        we_next.s = 1'b1;
        we_next.z = 1'b1;
        we_next.o = is_neg; // [RULE_19]
        we_next.c = is_neg; // [RULE_20]
        fl_next.s = un_s; // [RULE_21]
        fl_next.z = un_z; // [RULE_21]
        fl_next.o = is_neg & neg_o; // [RULE_19]
        fl_next.c = is_neg & neg_c; // [RULE_20]
      end
      nem_pkg::OP_IDLE: begin
        pc_next = 1'b1; // [RULE_23] nothing else is written
      end
      default: begin
        tg_next = nem_pkg::TG_NONE;
      end
    endcase
  end

  // answer sequencer: one answer cycle per accepted request
  nem_pkg::nem_state_type st_reg;
  nem_pkg::nem_state_type st_next;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      nem_pkg::ST_IDLE: st_next = accept ? nem_pkg::ST_DONE : nem_pkg::ST_IDLE;
      nem_pkg::ST_DONE: st_next = accept ? nem_pkg::ST_DONE : nem_pkg::ST_IDLE;
      default: st_next = nem_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg <= nem_pkg::ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // result flops; held values are only meaningful with o_done
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_done <= 1'b0;
      o_refused <= 1'b0;
      o_target <= nem_pkg::TG_NONE;
      o_width <= nem_pkg::WW_BYTE;
      o_result <= 48'h0;
      o_flag_we <= '0;
      o_flags <= '0;
      o_pc_inc <= 4'h0;
    end else begin
      o_done <= (st_next == nem_pkg::ST_DONE);
      o_refused <= refuse;
      o_target <= accept ? tg_next : nem_pkg::TG_NONE;
      o_width <= ww_next;
      o_result <= res_next;
      o_flag_we <= accept ? we_next : '0;
      o_flags <= fl_next;
      o_pc_inc <= (accept & pc_next) ? `NEM_PC_STEP : 4'h0; // [RULE_23]
    end
  end

  // register port decode
  wire logic hit_ctrl = (i_reg_addr == `NEM_OFF_CTRL);
  wire logic hit_stat = (i_reg_addr == `NEM_OFF_STAT);
  wire logic [15:0] cnt_ext = 16'(cnt_reg);
  wire logic [31:0] stat_word = ({16'h0, cnt_ext} << `NEM_STAT_CNT_LSB)
                              | ({28'h0, last_flg_reg} << `NEM_STAT_FLG_LSB);
  wire logic [31:0] rd_mux = hit_ctrl ? ctrl_reg : hit_stat ? stat_word : 32'h0;

  // only the enable bit is implemented; other control bits read zero
  assign ctrl_next = (i_reg_wr && hit_ctrl)
                   ? (i_reg_wdata & `NEM_CTRL_RST) : ctrl_reg;
  // a status write clears the counter, but an accept that cycle still counts
  assign cnt_next = (accept ? CNT_W'(1) : CNT_W'(0))
                  + ((i_reg_wr && hit_stat) ? CNT_W'(0) : cnt_reg);
  assign last_flg_next = (accept && (we_next != '0)) ? fl_next : last_flg_reg;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_reg <= `NEM_CTRL_RST;
      cnt_reg <= '0;
      last_flg_reg <= '0;
      o_reg_rdata <= 32'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      cnt_reg <= cnt_next;
      last_flg_reg <= last_flg_next;
      o_reg_rdata <= i_reg_rd ? rd_mux : 32'h0;
    end
  end

endmodule : nem_alu

// >>> verif/nem_feeder.sv
// decoder and operand-fetch stand-in that issues decoded requests to the slice
// assumes the bench hands it one request per cycle while i_go is high
module nem_feeder (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // request from the bench
  input wire logic i_go,
  input wire nem_pkg::nem_req_type i_req_in,
  // request towards the slice
  output logic o_req_valid,
  output nem_pkg::nem_req_type o_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // only legal operand pairings arrive here
  // operands are scrambled between requests so a stale value is never trusted
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_req_valid <= 1'b0;
      o_req <= '0;
    end else begin
      o_req_valid <= i_go;
      o_req <= i_go ? i_req_in : ~o_req;
    end
  end
endmodule : nem_feeder

// >>> verif/nem_alu_properties.sv
// assertion checker for the datapath slice, bound to its top module
// assumes answers come one cycle after the request that caused them
`include "nem_defines.svh"
module nem_alu_properties #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // request and answer
  input wire logic i_req_valid,
  input wire nem_pkg::nem_req_type i_req,
  input wire logic o_done,
  input wire logic o_refused,
  input wire nem_pkg::nem_target_type o_target,
  input wire nem_pkg::nem_width_type o_width,
  input wire logic [47:0] o_result,
  input wire nem_pkg::nem_flags_type o_flag_we,
  input wire nem_pkg::nem_flags_type o_flags,
  input wire logic [3:0] o_pc_inc,
  // register port
  input wire logic [`NEM_REG_AW-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  nem_pkg::nem_req_type p;
  // copy of the request seen at the last edge, so each answer ties to its cause
  always_ff @(posedge i_core_clk) p <= i_req;
  wire logic [3:0] nib = p.dir[1] ? p.src[3:0] : p.src[7:4];
  wire logic sz_b = p.size == nem_pkg::SZ_BYTE;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  a_nibble_move: assert property (o_done && p.op == nem_pkg::OP_NIBBLE |->
    o_result[7:0] == (p.dir[0] ? {p.dst[7:4], nib} : {nib, p.dst[3:0]}) && o_flag_we == 4'h0)
    else $error("nibble move result or flags wrong");
  a_extend_fill: assert property (o_done && p.op == nem_pkg::OP_EXTMOV |->
    o_result[23:0] == {{16{p.src[7]}}, p.src[7:0]} &&
    o_result[47:24] == (p.dst_is_addr ? 24'h0 : {16'h0, {8{p.src[7]}}}))
    else $error("extend move value wrong");
  a_extend_flags: assert property (o_done && p.op == nem_pkg::OP_EXTMOV |->
    o_flag_we == 4'hC && o_flags.s == p.src[7] && o_flags.z == (p.src[7:0] == 8'h0))
    else $error("extend move flags wrong");
  a_wide_signed: assert property (o_done && p.op == nem_pkg::OP_SIGNED_WIDE_MULTIPLY |->
    $signed(o_result) == $signed(p.src[15:0]) * $signed(p.pair) && o_flag_we == 4'h0)
    else $error("wide signed product wrong");
  a_byte_product: assert property (o_done && p.op == nem_pkg::OP_UNSIGNED_MULTIPLY && sz_b |->
    o_result == p.src[7:0] * p.dst[7:0] && o_flag_we == 4'h0)
    else $error("byte product wrong");
  a_neg_carry: assert property (o_done && p.op == nem_pkg::OP_NEG && sz_b |->
    o_result[7:0] == 8'h0 - p.dst[7:0] && o_flags.o == (p.dst[7:0] == `NEM_NEG_MIN_B) &&
    o_flags.c == (o_result[7:0] == 8'h0))
    else $error("negate flags wrong");
  a_idle_only_pc: assert property (o_done && p.op == nem_pkg::OP_IDLE |->
    o_pc_inc == `NEM_PC_STEP && o_flag_we == 4'h0 && o_target == nem_pkg::TG_NONE)
    else $error("idle instruction changed state");
  a_invert_word: assert property (o_done && p.op == nem_pkg::OP_NOT && !sz_b |->
    o_result[15:0] == ~p.dst[15:0] && o_flags.s == o_result[15] && o_result[47:16] == 32'h0)
    else $error("word invert wrong");
endmodule : nem_alu_properties
bind nem_alu nem_alu_properties #(.CNT_W(CNT_W)) u_props (.i_core_clk, .i_rst_b, .i_req_valid,
  .i_req, .o_done, .o_refused, .o_target, .o_width, .o_result, .o_flag_we, .o_flags, .o_pc_inc,
  .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata);

// >>> verif/tb.sv
// self-checking bench for the datapath slice with a scoreboard queue
// assumes the feeder model stands in for the decoder and the checker is bound
`include "nem_defines.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] hs;
    nem_pkg::nem_op_type op;
    logic [53:0] e1;
    logic [11:0] e2;
  } nem_tb_exp_type;
  logic i_core_clk = 0, i_rst_b = 0, go = 0, i_reg_wr = 0, i_reg_rd = 0, rd_d = 0;
  logic i_req_valid, o_done, o_refused;
  logic [3:0] i_reg_addr = 4'h0, o_pc_inc;
  logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata;
  logic [47:0] o_result;
  nem_pkg::nem_req_type req_in = '0, i_req, r;
  nem_pkg::nem_target_type o_target;
  nem_pkg::nem_width_type o_width;
  nem_pkg::nem_flags_type o_flag_we, o_flags;
  nem_tb_exp_type q[$], note;
  logic [31:0] rq[$];
  logic [31:0] rexp;
  int fails = 0, checked = 0;
  integer seed = 7139;
  always #5 i_core_clk = ~i_core_clk;
  nem_feeder FEED (.i_core_clk, .i_rst_b, .i_go(go), .i_req_in(req_in), .o_req_valid(i_req_valid),
    .o_req(i_req));
  nem_alu #(.CNT_W(16)) DUT (.i_core_clk, .i_rst_b, .i_req_valid, .i_req, .o_done, .o_refused,
    .o_target, .o_width, .o_result, .o_flag_we, .o_flags, .o_pc_inc, .i_reg_addr, .i_reg_wdata,
    .i_reg_wr, .i_reg_rd, .o_reg_rdata);
  // expected answer of one accepted request
  function automatic nem_tb_exp_type model(nem_pkg::nem_req_type a);
    logic [31:0] s, d, x;
    logic signed [47:0] w;
    logic ng, by;
    nem_tb_exp_type e;
    s = a.src_is_addr ? {8'h0, a.src[23:0]} : a.src;
    d = a.dst;
    e = {2'b10, a.op, 66'h0};
    ng = a.op == nem_pkg::OP_NEG;
    by = a.size == nem_pkg::SZ_BYTE;
    case (a.op)
      nem_pkg::OP_NIBBLE: begin
        x = a.dir[0] ? {d[7:4], a.dir[1] ? s[3:0] : s[7:4]} : {a.dir[1] ? s[3:0] : s[7:4], d[3:0]};
        e.e1 = {nem_pkg::TG_DEST, nem_pkg::WW_BYTE, 40'h0, x[7:0]};
      end
      nem_pkg::OP_EXTMOV: begin
        x = {{24{s[7]}}, s[7:0]};
        e.e1 = a.dst_is_addr ? {nem_pkg::TG_DEST, nem_pkg::WW_ADDR24, 24'h0, x[23:0]}
          : {nem_pkg::TG_DEST, nem_pkg::WW_LONG, 16'h0, x};
        e.e2 = {4'hC, x[31], x == 32'h0, 6'h0};
      end
      nem_pkg::OP_SIGNED_WIDE_MULTIPLY: begin
        w = $signed(s[15:0]) * $signed(a.pair);
        e.e1 = {nem_pkg::TG_TRIPLE, nem_pkg::WW_WIDE48, w};
      end
      nem_pkg::OP_UNSIGNED_MULTIPLY: begin
        w = by ? s[7:0] * d[7:0] : a.size == nem_pkg::SZ_WORD ? s[15:0] * d[15:0] : s * d;
        if (by) e.e1 = {nem_pkg::TG_DEST, a.dst_is_addr ? nem_pkg::WW_ADDR24 : nem_pkg::WW_WORD, w};
        else if (a.dst_is_addr) e.e1 = {nem_pkg::TG_DEST, nem_pkg::WW_ADDR24, 24'h0, w[23:0]};
        else e.e1 = {a.size == nem_pkg::SZ_WORD && a.dst_word_one ? nem_pkg::TG_SECOND_PAIR
          : nem_pkg::TG_FIRST_PAIR, nem_pkg::WW_LONG, 16'h0, w[31:0]};
      end
      nem_pkg::OP_NEG, nem_pkg::OP_NOT: begin
        x = ng ? 32'h0 - d : ~d;
        x = by ? {24'h0, x[7:0]} : {16'h0, x[15:0]};
        e.e1 = {nem_pkg::TG_DEST, by ? nem_pkg::WW_BYTE : a.dst_is_addr ? nem_pkg::WW_ADDR24
          : nem_pkg::WW_WORD, 16'h0, x};
        e.e2 = {ng ? 4'hF : 4'hC, by ? x[7] : x[15], x == 32'h0, ng & (by ? d[7:0] == 8'h80
          : d[15:0] == 16'h8000), ng & (x == 32'h0), 4'h0};
      end
      default: e.e2 = {8'h0, `NEM_PC_STEP};
    endcase
    return e;
  endfunction : model
  // scoreboard: each answer, refusal or read takes the oldest note
  always @(negedge i_core_clk) begin
    if (o_done | o_refused) begin
      note = q.size() ? q.pop_front() : '0;
      `CHK({o_done, o_refused}, note.hs)
      if (o_done && note.op == nem_pkg::OP_IDLE) `CHK(o_target, note.e1[53:51])
      else if (o_done) `CHK({o_target, o_width, o_result}, note.e1)
      if (o_done) `CHK({o_flag_we, o_flags & o_flag_we, o_pc_inc}, note.e2)
    end
    // take the note once; the compare macro reads its expected value twice
    if (rd_d) begin
      rexp = rq.size() ? rq.pop_front() : 32'hDEAD_BEEF;
      `CHK(o_reg_rdata, rexp)
    end
  end
  always @(posedge i_core_clk) rd_d <= i_reg_rd;
  // bus drivers: each sets every strobe once per edge, so calls may run back to back
  task automatic reg_wr(input logic [3:0] ad, input logic [31:0] wd);
    {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} <= {2'b10, ad, wd};
    go <= 1'b0;
    @(posedge i_core_clk);
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] ad, input logic [31:0] ex);
    {i_reg_wr, i_reg_rd, i_reg_addr} <= {2'b01, ad};
    go <= 1'b0;
    rq.push_back(ex);
    @(posedge i_core_clk);
  endtask : reg_rd
  task automatic send(input nem_pkg::nem_req_type a, input logic ok);
    go <= 1'b1;
    {i_reg_wr, i_reg_rd} <= 2'b00;
    req_in <= a;
    q.push_back(ok ? model(a) : {2'b01, a.op, 66'h0});
    @(posedge i_core_clk);
  endtask : send
  task automatic quiet;
    {go, i_reg_wr, i_reg_rd} <= 3'h0;
    @(posedge i_core_clk);
  endtask : quiet
  task automatic complete_run;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  // watchdog: the whole sequence needs about 320 cycles
  initial begin
    repeat (3000) @(posedge i_core_clk);
    fails++;
    complete_run;
  end
  // main sequence: registers, a refusal, all ops back to back, counter clear
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    reg_rd(`NEM_OFF_CTRL, `NEM_CTRL_RST);
    reg_rd(4'h8, 32'h0);
    reg_wr(`NEM_OFF_CTRL, 32'hFFFF_FFFE);
    reg_rd(`NEM_OFF_CTRL, 32'h0);
    r = '0;
    send(r, 1'b0);
    quiet;
    reg_wr(`NEM_OFF_CTRL, 32'hFFFF_FFFF);
    reg_rd(`NEM_OFF_CTRL, 32'h1);
    reg_rd(`NEM_OFF_STAT, 32'h0);
    quiet;
    for (int i = 0; i < 300; i++) begin
      r.op = nem_pkg::nem_op_type'(i % 7);
      r.size = nem_pkg::nem_size_type'((i / 7) % 3);
      r.dir = nem_pkg::nem_dir_type'(i % 4);
      {r.src_is_addr, r.dst_is_addr, r.dst_word_one} = 3'($random(seed));
      r.src = i % 5 == 0 ? 32'h80 : i % 5 == 1 ? 32'h0 : $random(seed);
      r.dst = i % 5 == 0 ? 32'h8000 : i % 5 == 1 ? 32'h80 : $random(seed);
      r.pair = $random(seed);
      if (r.size == nem_pkg::SZ_LONG) r.dst_is_addr = 1'b0;
      if (r.size == nem_pkg::SZ_BYTE) r.src_is_addr &= !r.dst_is_addr;
      if (r.src_is_addr) r.src[31:24] = 8'h0;
      if (r.dst_is_addr) r.dst[31:24] = 8'h0;
      send(r, 1'b1);
    end
    quiet;
    reg_wr(`NEM_OFF_STAT, 32'h0);
    r = '0;
    r.op = nem_pkg::OP_NEG;
    r.dst = 32'h80;
    send(r, 1'b1);
    quiet;
    quiet;
    reg_rd(`NEM_OFF_STAT, 32'h000A_0001);
    quiet;
    quiet;
    complete_run;
  end
endmodule : tb
